// ===== src/sld_pkg.sv
// Constants, frame layout, register map and state type of the link receiver.
// Assumes a 100 MHz system clock and one frame strobe per pixel clock.
package sld_pkg;
	// Clock rate and timing
	localparam int CLK_PERIOD_NS   = 10;                 // System clock period
	localparam int STOP_TIME_NS    = 1000;               // Longest gap before a stop
	localparam int STOP_CYCLES     = STOP_TIME_NS / CLK_PERIOD_NS; // Longest time rounds down
	localparam int LOCK_FRAMES     = 4;                  // Good frames needed for lock
	localparam int OSC_HALF_CYCLES = 5;                  // Internal oscillator half period
	// Spread modulation divisors, in pixel clocks
	localparam int MOD_DIV_HI_A    = 2168;               // Upper range, codes 1 to 4
	localparam int MOD_DIV_HI_B    = 1300;               // Upper range, codes 5 to 7
	localparam int MOD_DIV_LO_A    = 625;                // Lower range, codes 1 to 4
	localparam int MOD_DIV_LO_B    = 385;                // Lower range, codes 5 to 7
	// Frame layout
	localparam int FRAME_W         = 28;                 // Bits per frame
	localparam int PAYLOAD_W       = 24;                 // Payload bits per frame
	localparam int POS_MARK_HI     = 27;                 // Clock marker, always high
	localparam int POS_PAY_LSB     = 3;                  // Payload lowest bit
	localparam int POS_BALANCE     = 2;                  // Inversion flag
	localparam int POS_INTEGRITY   = 1;                  // Parity over sent payload
	localparam int POS_MARK_LO     = 0;                  // Clock marker, always low
	localparam int POS_OS_A        = 21;                 // Payload bit to over-sampled 0
	// Register map, byte addresses
	localparam logic [3:0] ADDR_CTRL   = 4'h0;           // Override word
	localparam logic [3:0] ADDR_CONFIG = 4'h4;           // Config bits
	localparam logic [3:0] ADDR_STATUS = 4'h8;           // Link status
	localparam logic [3:0] ADDR_ERRCNT = 4'hC;           // Integrity error count
	localparam logic [7:0] CTRL_RESET  = 8'h00;          // Pins in control
	localparam logic [7:0] CTRL_OVERRIDE = 8'h01;        // Registers in control
	localparam logic [7:0] CONFIG_RESET = 8'h00;         // Config defaults
	localparam int CFG_SPREAD_LSB  = 0;                  // Spread code, 3 bits
	localparam int CFG_OUT_EN      = 3;                  // Output drive enable
	localparam int CFG_OSC_SEL     = 4;                  // Oscillator clock when unlocked
	localparam int CFG_SLEEP_SEL   = 6;                  // Sleep state select
	localparam int CFG_LOW_FREQ    = 7;                  // Low frequency range
	// Receiver states
	typedef enum logic [1:0] {SLD_DOWN, SLD_ACQUIRE, SLD_LOCKED} sld_state_t;
endpackage

// ===== src/sld_deserializer.sv
// Receive side of an embedded-clock serial link: frame check, decode, lock,
// output state selection, spread modulation timing and an Avalon-MM slave.
// Assumes frames arrive already parallel, one strobe per pixel clock, sync to clk.
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Extract 24 payload bits every frame
// - Marker bits high/low give frame timing
// - Invert payload when balance bit set
// - Check integrity bit on every frame
// - Pixel clock 5 to 43 MHz supported
// - Lock to any data, no training
// - Over-sampled outputs are payload bits 21-23
// - Power-up: acquire, lock low, sleep-select outputs
// - Lock high then valid data and clock
// - Clock source switch holds clock level
// - Embedded clock lost: unlock, sleep-select outputs
// - Powered down outputs per sleep select
// - Unlocked, enable low output states
// - Unlocked, enable high output states
// - Locked, enable low: link outputs off
// - Locked, enable high: all outputs active
// - Upper range spread divisors 2168 and 1300
// - Lower range spread divisors 625 and 385
// - Spread gives modulation timing only, clock and data not modulated
// - Stream stop drops to acquisition, restart relocks
// - Power down resets control registers
// - Stop sleep retains registers, then relocks
// - Control word 01h gives registers priority
module sld_deserializer
	import sld_pkg::*;
(
	input  wire logic                 clk,                 // System clock, 100 MHz
	input  wire logic                 nrst,                // Sync reset, active low
	input  wire logic                 frame_valid,         // One frame this cycle
	input  wire logic [FRAME_W-1:0]   frame_data,          // Received frame
	input  wire logic                 power_down_bar,      // Low powers down
	input  wire logic                 sleep_state_select,  // Pin sleep select
	input  wire logic                 output_drive_enable, // Pin output enable
	input  wire logic                 low_freq_range,      // Pin range select
	input  wire logic [2:0]           spread_setting,      // Pin spread code
	input  wire logic [3:0]           avs_address,         // Byte address
	input  wire logic                 avs_read,            // Read request
	input  wire logic                 avs_write,           // Write request
	input  wire logic [31:0]          avs_writedata,       // Write data
	input  wire logic [3:0]           avs_byteenable,      // Byte lanes
	output logic      [31:0]          avs_readdata,        // Read data
	output logic                      avs_waitrequest,     // Stall
	output logic                      lock,                // Lock flag
	output logic                      lock_oe_n,           // Lock drive, low drives
	output logic                      link_clock_out,      // Output clock
	output logic                      link_clock_oe_n,     // Low drives
	output logic      [PAYLOAD_W-1:0] link_data_out,       // Recovered payload
	output logic                      link_data_oe_n,      // Low drives
	output logic      [2:0]           oversampled_outputs, // Low-speed bits
	output logic                      oversampled_oe_n,    // Low drives
	output logic                      test_pass,           // Self-test result
	output logic                      test_pass_oe_n,      // Low drives
	output logic                      spread_active,       // Modulation on
	output logic                      spread_phase         // Modulation half period
);
	////////////////////////////////////////////////////////////////////////////
	// Declarations
	sld_state_t             state;           // Receiver state
	logic [2:0]             good_count;      // Consecutive good frames
	logic [7:0]             idle_count;      // Cycles since last frame
	logic                   stopped;         // Stream stopped
	logic [7:0]             ctrl_reg;        // Override word
	logic [7:0]             config_reg;      // Config bits
	logic [15:0]            err_count;       // Integrity errors
	logic                   ack;             // Bus answer cycle
	logic                   powered;         // Pin not in power down
	logic                   override;        // Registers have priority
	logic                   sel_sleep;       // Effective sleep select
	logic                   sel_oen;         // Effective output enable
	logic                   sel_lfr;         // Effective range
	logic [2:0]             sel_spread;      // Effective spread code
	logic                   marks_ok;        // Marker pair correct
	logic [PAYLOAD_W-1:0]   raw_payload;     // Payload as sent
	logic [PAYLOAD_W-1:0]   next_payload;    // Payload after balance undo
	logic                   parity_ok;       // Integrity check
	logic                   frame_good;      // Frame valid and correct
	logic [PAYLOAD_W-1:0]   payload_q;       // Last recovered payload
	logic                   pass_q;          // No integrity error since lock
	logic                   src_recovered;   // Clock source selection
	logic                   src_prev;        // Previous source
	logic [2:0]             osc_count;       // Oscillator divider
	logic                   osc_tick;        // Oscillator edge enable
	logic                   clk_level;       // Output clock level
	logic [11:0]            mod_count;       // Spread divider, pixel clocks
	logic [11:0]            mod_div;         // Selected divisor

	////////////////////////////////////////////////////////////////////////////
	// Effective configuration: pins unless the override word is set
	assign powered    = power_down_bar;
	assign override   = (ctrl_reg == CTRL_OVERRIDE);
	assign sel_sleep  = override ? config_reg[CFG_SLEEP_SEL] : sleep_state_select;
	assign sel_oen    = override ? config_reg[CFG_OUT_EN] : output_drive_enable;
	assign sel_lfr    = override ? config_reg[CFG_LOW_FREQ] : low_freq_range;
	assign sel_spread = override ? config_reg[CFG_SPREAD_LSB +: 3] : spread_setting;

	////////////////////////////////////////////////////////////////////////////
	// Frame decode
	assign marks_ok    = frame_data[POS_MARK_HI] & ~frame_data[POS_MARK_LO];
	assign raw_payload = frame_data[POS_PAY_LSB +: PAYLOAD_W];
	assign next_payload = frame_data[POS_BALANCE] ? ~raw_payload : raw_payload;
	assign parity_ok   = (^raw_payload) == frame_data[POS_INTEGRITY];
	assign frame_good  = frame_valid & marks_ok & parity_ok;

	////////////////////////////////////////////////////////////////////////////
	// Stop detection: no frame strobe for the stop time
	always_ff @(posedge clk)
	begin
		if (!nrst || !powered || frame_valid)
		begin
			idle_count <= 8'h00;
			stopped    <= 1'b0;
		end
		else if (idle_count >= 8'(STOP_CYCLES - 1))
		begin
			stopped <= 1'b1;
		end
		else
		begin
			idle_count <= idle_count + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Lock state machine
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state      <= SLD_DOWN;
			good_count <= 3'h0;
		end
		else
		begin
			case (state)
				SLD_DOWN:
				begin
					good_count <= 3'h0;
					// Power up starts acquisition at once
					if (powered)
						state <= SLD_ACQUIRE;
				end
				SLD_ACQUIRE:
				begin
					if (!powered)
						state <= SLD_DOWN;
					else if (frame_valid && !frame_good)
						good_count <= 3'h0;
					else if (frame_good && good_count == 3'(LOCK_FRAMES - 1))
						state <= SLD_LOCKED;
					else if (frame_good)
						good_count <= good_count + 3'h1;
				end
				SLD_LOCKED:
				begin
					good_count <= 3'h0;
					// Lost markers or stopped stream drop lock
					if (!powered)
						state <= SLD_DOWN;
					else if ((frame_valid && !marks_ok) || stopped)
						state <= SLD_ACQUIRE;
				end
				default:
				begin
					state <= SLD_DOWN;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Payload register: one clock of latency while locked
	always_ff @(posedge clk)
	begin
		if (!nrst)
			payload_q <= 24'h000000;
		else if (frame_valid && state == SLD_LOCKED && marks_ok)
			payload_q <= next_payload;
	end

	////////////////////////////////////////////////////////////////////////////
	// Integrity result cleared by power down or new acquisition, error count by power down only
	always_ff @(posedge clk)
	begin
		if (!nrst || !powered || state == SLD_ACQUIRE)
			pass_q <= 1'b1;
		else if (frame_valid && marks_ok && !parity_ok)
			pass_q <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst || !powered)
			err_count <= 16'h0000;
		else if (frame_valid && marks_ok && !parity_ok && err_count != 16'hFFFF)
			err_count <= err_count + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock level: recovered when locked, else oscillator if CFG_OSC_SEL set (driven out only when
	// locked); a source change swallows one edge so the level holds over the switch
	assign src_recovered = (state == SLD_LOCKED);
	assign osc_tick      = (osc_count == 3'(OSC_HALF_CYCLES - 1));

	always_ff @(posedge clk)
	begin
		if (!nrst || osc_tick)
			osc_count <= 3'h0;
		else
			osc_count <= osc_count + 3'h1;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			clk_level <= 1'b0;
			src_prev  <= 1'b0;
		end
		else
		begin
			src_prev <= src_recovered;
			if (src_prev != src_recovered)
				clk_level <= clk_level;
			else if (src_recovered ? frame_valid
				: (osc_tick && config_reg[CFG_OSC_SEL]))
				clk_level <= ~clk_level;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Spread modulation timing, counted in pixel clocks
	always_comb
	begin
		if (sel_lfr)
			mod_div = (sel_spread[2] && sel_spread[1:0] != 2'b00)
				? 12'(MOD_DIV_LO_B) : 12'(MOD_DIV_LO_A);
		else
			mod_div = (sel_spread[2] && sel_spread[1:0] != 2'b00)
				? 12'(MOD_DIV_HI_B) : 12'(MOD_DIV_HI_A);
	end

	always_ff @(posedge clk)
	begin
		if (!nrst || sel_spread == 3'h0)
		begin
			mod_count     <= 12'h000;
			spread_active <= 1'b0;
			spread_phase  <= 1'b0;
		end
		else if (frame_valid)
		begin
			spread_active <= 1'b1;
			mod_count     <= (mod_count >= mod_div - 12'h001) ? 12'h000
				: mod_count + 12'h001;
			spread_phase  <= (mod_count >= (mod_div >> 1));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output state table, registered
	always_ff @(posedge clk)
	begin
		if (!nrst || !powered)
		begin
			// Powered down
			lock                <= 1'b0;
			lock_oe_n           <= ~sel_sleep;
			link_clock_out      <= 1'b0;
			link_clock_oe_n     <= 1'b1;
			link_data_out       <= 24'h000000;
			link_data_oe_n      <= 1'b1;
			oversampled_outputs <= 3'h0;
			oversampled_oe_n    <= ~sel_sleep;
			test_pass           <= 1'b0;
			test_pass_oe_n      <= 1'b1;
		end
		else if (state != SLD_LOCKED)
		begin
			// Powered, not locked
			lock                <= 1'b0;
			lock_oe_n           <= 1'b0;
			link_clock_out      <= 1'b0;
			link_clock_oe_n     <= 1'b1;
			link_data_out       <= 24'h000000;
			link_data_oe_n      <= ~(sel_oen & sel_sleep);
			oversampled_outputs <= 3'h0;
			oversampled_oe_n    <= sel_oen & ~sel_sleep;
			test_pass           <= ~sel_sleep;
			test_pass_oe_n      <= 1'b0;
		end
		else
		begin
			// Locked
			lock                <= 1'b1;
			lock_oe_n           <= 1'b0;
			link_clock_out      <= clk_level;
			link_clock_oe_n     <= ~sel_oen;
			link_data_out       <= payload_q;
			link_data_oe_n      <= ~sel_oen;
			oversampled_outputs <= payload_q[POS_OS_A +: 3];
			oversampled_oe_n    <= 1'b0;
			test_pass           <= pass_q;
			test_pass_oe_n      <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle, then answer
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;

	always_ff @(posedge clk)
	begin
		if (!nrst)
			ack <= 1'b0;
		else
			ack <= (avs_read | avs_write) & ~ack;
	end

	// Control and config registers, back to defaults in power down
	always_ff @(posedge clk)
	begin
		if (!nrst || !powered)
		begin
			ctrl_reg   <= CTRL_RESET;
			config_reg <= CONFIG_RESET;
		end
		else if (avs_write && ack && avs_byteenable[0])
		begin
			if (avs_address == ADDR_CTRL)
				ctrl_reg <= avs_writedata[7:0];
			else if (avs_address == ADDR_CONFIG)
				config_reg <= avs_writedata[7:0];
		end
	end

	// Read data captured in the wait cycle
	always_ff @(posedge clk)
	begin
		if (!nrst)
			avs_readdata <= 32'h00000000;
		else if (avs_read && !ack)
		begin
			case (avs_address)
				ADDR_CTRL:   avs_readdata <= {24'h000000, ctrl_reg};
				ADDR_CONFIG: avs_readdata <= {24'h000000, config_reg};
				ADDR_STATUS: avs_readdata <= {27'h0000000, pass_q, stopped,
					spread_active, powered, (state == SLD_LOCKED)};
				ADDR_ERRCNT: avs_readdata <= {16'h0000, err_count};
				default:     avs_readdata <= 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	// Locked frame arrives with a broken marker pair
	sequence s_marker_loss;
		power_down_bar && state == SLD_LOCKED && frame_valid && !marks_ok;
	endsequence

	// Back to acquisition, then the lock flag falls
	sequence s_unlock_steps;
		state == SLD_ACQUIRE ##1 !lock;
	endsequence

	a_lock_needs_power: assert property (@(posedge clk) disable iff (!nrst)
		!power_down_bar |=> !lock)
		else $error("lock high after power down");

	a_lock_after_state: assert property (@(posedge clk) disable iff (!nrst)
		(state == SLD_LOCKED && power_down_bar) |=> lock)
		else $error("lock not shown one cycle after locked state");

	a_bad_marker_drop: assert property (@(posedge clk) disable iff (!nrst)
		s_marker_loss |=> s_unlock_steps)
		else $error("lock kept after marker loss");

	a_pd_outputs: assert property (@(posedge clk) disable iff (!nrst)
		!power_down_bar |=> link_clock_oe_n && link_data_oe_n && test_pass_oe_n
		&& oversampled_oe_n == !$past(sel_sleep))
		else $error("power down output states wrong");

	a_unlocked_en_low: assert property (@(posedge clk) disable iff (!nrst)
		(power_down_bar && state != SLD_LOCKED && !sel_oen) |=> !oversampled_oe_n
		&& oversampled_outputs == 3'h0 && test_pass == !$past(sel_sleep))
		else $error("unlocked enable low states wrong");

	a_unlocked_en_high: assert property (@(posedge clk) disable iff (!nrst)
		(power_down_bar && state != SLD_LOCKED && sel_oen && sel_sleep)
		|=> !link_data_oe_n && link_data_out == 24'h000000 && link_clock_oe_n)
		else $error("unlocked enable high states wrong");

	a_locked_drive: assert property (@(posedge clk) disable iff (!nrst)
		(power_down_bar && state == SLD_LOCKED) |=> link_data_oe_n == !$past(sel_oen)
		&& !oversampled_oe_n && !test_pass_oe_n)
		else $error("locked drive states wrong");

	a_payload_path: assert property (@(posedge clk) disable iff (!nrst)
		(frame_valid && marks_ok && state == SLD_LOCKED && power_down_bar)
		##1 (power_down_bar && state == SLD_LOCKED)
		|=> link_data_out == $past(next_payload, 2)
		&& oversampled_outputs == link_data_out[23:21])
		else $error("payload latency or decode wrong");

	a_clock_hold: assert property (@(posedge clk) disable iff (!nrst)
		(src_prev != src_recovered) |=> $stable(clk_level))
		else $error("clock level moved at source switch");

	a_pd_reg_reset: assert property (@(posedge clk) disable iff (!nrst)
		!power_down_bar |=> ctrl_reg == CTRL_RESET && config_reg == CONFIG_RESET)
		else $error("registers not reset in power down");

	a_lock_acquire: assert property (@(posedge clk) disable iff (!nrst)
		(state == SLD_ACQUIRE && frame_valid && !frame_good) |=> good_count == 3'h0)
		else $error("bad frame did not restart acquisition");

	a_bus_answer: assert property (@(posedge clk) disable iff (!nrst)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer not after one wait");

	a_spread_div: assert property (@(posedge clk) disable iff (!nrst)
		(sel_spread != 3'h0) |-> mod_div == (sel_lfr
		? ((sel_spread > 3'h4) ? 12'h181 : 12'h271)
		: ((sel_spread > 3'h4) ? 12'h514 : 12'h878)))
		else $error("spread divisor wrong");
endmodule

// ===== verification/sld_ser_model.sv
// Serializer model: sends one embedded-clock frame per send request.
// Assumes it shares clk and nrst with the receiver under test.
`timescale 1ns/1ps
module sld_ser_model
	import sld_pkg::*;
(
	input  wire logic                 clk,         // System clock
	input  wire logic                 nrst,        // Sync reset, active low
	input  wire logic                 send,        // Send one frame
	input  wire logic [23:0]          payload,     // Original payload
	input  wire logic                 invert,      // Send inverted payload
	input  wire logic                 bad_par,     // Corrupt integrity bit
	input  wire logic                 bad_mark,    // Corrupt high marker
	output logic                      frame_valid, // Frame strobe
	output logic      [FRAME_W-1:0]   frame_data   // Frame bits
);
	logic [23:0] sent; // Payload as it goes on the wire
	assign sent = invert ? ~payload : payload;
	// Frame on request; between frames the line keeps changing
	always_ff @(posedge clk)
	begin
		frame_valid <= send && nrst;
		if (!nrst)
			frame_data <= '0;
		else if (send)
			frame_data <= {~bad_mark, sent, invert, ^sent ^ bad_par, 1'b0};
		else
			frame_data <= ~frame_data;
	end
endmodule

// ===== verification/sld_deserializer_tb_top.sv
// Testbench for the link receiver: table of frames, then awkward cases.
// Assumes the serializer model and a 100 MHz clock.
`timescale 1ns/1ps
module sld_deserializer_tb_top
	import sld_pkg::*;
;
	typedef struct packed {logic [23:0] pay; logic inv;} sld_row_t; // Payload, inversion
	sld_row_t rows [4] = '{'{24'hA5A5A5, 1'b0}, '{24'h000000, 1'b1},
		'{24'hFFFFFF, 1'b0}, '{24'h3C0F81, 1'b1}}; // Slow OS bits
	logic clk, nrst, power_down_bar, sleep_state_select, output_drive_enable;
	logic low_freq_range, avs_read, avs_write, send, inv, bpar, bmark;
	logic frame_valid, avs_waitrequest, lock, lock_oe_n, link_clock_out, link_clock_oe_n;
	logic link_data_oe_n, oversampled_oe_n, test_pass, test_pass_oe_n, spread_active;
	logic spread_phase, c; // c: clock level before a row
	logic [2:0]         spread_setting, oversampled_outputs; // Spread code, OS bits
	logic [3:0]         avs_address, avs_byteenable;        // Bus address, lanes
	logic [31:0]        avs_writedata, avs_readdata, q;     // Bus data
	logic [23:0]        pay, link_data_out;                 // Payload in and out
	logic [FRAME_W-1:0] frame_data;                         // Frame bits
	int                 mismatches, n_compared;             // Counters
	sld_ser_model i_ser (.clk, .nrst, .send, .payload(pay), .invert(inv), .bad_par(bpar),
		.bad_mark(bmark), .frame_valid, .frame_data);
	sld_deserializer i_dut (.clk, .nrst, .frame_valid, .frame_data, .power_down_bar,
		.sleep_state_select, .output_drive_enable, .low_freq_range, .spread_setting,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .lock, .lock_oe_n, .link_clock_out, .link_clock_oe_n,
		.link_data_out, .link_data_oe_n, .oversampled_outputs, .oversampled_oe_n,
		.test_pass, .test_pass_oe_n, .spread_active, .spread_phase);
	////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic close_out;
		$display("Mismatches %0d, compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Compare one result
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One frame through the serializer model
	task automatic frame(input logic [23:0] p, input logic i, input logic bp, input logic bm);
		@(posedge clk);
		send <= 1'b1;
		pay <= p;
		inv <= i;
		bpar <= bp;
		bmark <= bm;
		@(posedge clk);
		send <= 1'b0;
	endtask
	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		if (n >= 20)
			mismatches++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// Wait for the lock flag to reach a level, bounded
	task automatic wait_lock(input logic v);
		for (int n = 0; n < 40 && lock !== v; n++)
			@(posedge clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#300000;
		mismatches++;
		close_out();
	end
	// Main sequence
	initial
	begin
		{nrst, avs_read, avs_write, send, inv, bpar, bmark, sleep_state_select} = '0;
		{low_freq_range, spread_setting, avs_address, avs_writedata, pay} = '0;
		{power_down_bar, output_drive_enable} = 2'b11;
		avs_byteenable = 4'hF;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		chk("lock", 0, lock);
		chk("data oe_n", 1, link_data_oe_n);
		chk("pass", 1, test_pass);
		bus(0, ADDR_CTRL, 0);
		chk("ctrl", CTRL_RESET, q);
		bus(0, 4'h2, 0);
		chk("unmapped", 0, q);
		repeat (4) frame(24'h123456, 0, 0, 0);
		wait_lock(1);
		chk("lock", 1, lock);
		foreach (rows[k])
		begin
			c = link_clock_out;
			// Each row held for five frames keeps OS levels slow
			repeat (5) frame(rows[k].pay, rows[k].inv, 0, 0);
			repeat (3) @(posedge clk);
			#1;
			chk("data", rows[k].pay, link_data_out);
			chk("os", rows[k].pay[23:21], oversampled_outputs);
			chk("data oe_n", 0, link_data_oe_n);
			chk("clock", !c, link_clock_out);
			chk("clock oe_n", 0, link_clock_oe_n);
		end
		frame(24'h0F0F0F, 0, 1, 0);
		repeat (3) @(posedge clk);
		#1;
		chk("pass", 0, test_pass);
		bus(0, ADDR_STATUS, 0);
		chk("status", 32'h00000003, q);
		bus(0, ADDR_ERRCNT, 0);
		chk("errcnt", 1, q);
		bus(1, ADDR_CTRL, CTRL_OVERRIDE);
		bus(1, ADDR_CONFIG, 8'h10); // Oscillator clock while unlocked
		repeat (2) @(posedge clk);
		#1;
		chk("data oe_n", 1, link_data_oe_n);
		chk("os oe_n", 0, oversampled_oe_n);
		chk("clock oe_n", 1, link_clock_oe_n);
		repeat (STOP_CYCLES + 10) @(posedge clk);
		#1;
		chk("lock", 0, lock);
		chk("pass", 1, test_pass);
		chk("os", 0, oversampled_outputs);
		chk("os oe_n", 0, oversampled_oe_n);
		bus(0, ADDR_CTRL, 0);
		chk("ctrl", CTRL_OVERRIDE, q);
		repeat (4) frame(24'h654321, 0, 0, 0);
		wait_lock(1);
		chk("lock", 1, lock);
		frame(24'h654321, 0, 0, 1);
		wait_lock(0);
		chk("lock", 0, lock);
		@(posedge clk);
		power_down_bar <= 1'b0;
		sleep_state_select <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("os", 0, oversampled_outputs);
		chk("os oe_n", 0, oversampled_oe_n);
		chk("pass oe_n", 1, test_pass_oe_n);
		chk("lock", 0, lock);
		chk("lock oe_n", 0, lock_oe_n);
		bus(0, ADDR_CTRL, 0);
		chk("ctrl", CTRL_RESET, q);
		@(posedge clk);
		power_down_bar <= 1'b1;
		spread_setting <= 3'b001;
		repeat (3) @(posedge clk);
		#1;
		chk("data", 0, link_data_out);
		chk("data oe_n", 0, link_data_oe_n);
		repeat (4) frame(24'h00ABCD, 0, 0, 0);
		#1;
		chk("spread", 1, spread_active);
		// Lower range, code 5: half of 385 frames is 192
		@(posedge clk);
		spread_setting <= 3'b000;
		@(posedge clk);
		spread_setting <= 3'b101;
		low_freq_range <= 1'b1; // Slow pixel clock range
		repeat (190) frame(24'h00ABCD, 0, 0, 0);
		repeat (2) @(posedge clk);
		#1;
		chk("phase", 0, spread_phase);
		repeat (10) frame(24'h00ABCD, 0, 0, 0);
		repeat (2) @(posedge clk);
		#1;
		chk("phase", 1, spread_phase);
		close_out();
	end
endmodule
